/* src/link_event_defines.svh */
`ifndef LINK_EVENT_DEFINES_SVH
`define LINK_EVENT_DEFINES_SVH

// Register offsets
`define OFF_SYSTEM_CONTROL_REG 8'h00
`define OFF_EVT_H 8'h04
`define OFF_EVT_L 8'h05
`define OFF_MASK_H 8'h06
`define OFF_MASK_L 8'h07
`define OFF_REMOTE_SUMMARY_MASK 8'h08
`define OFF_EDGES 8'h09

// System control bits
`define SYS_PROTO_RST_BIT 0
`define SYS_CHAN_RST_BIT 1

// High byte fields
`define HI_IRQ_BIT 7
`define HI_SUM_BIT 6
`define HI_POS_BIT 3
`define HI_DTE_BIT 1
`define HI_PROTOCOL_RESET_FLAG_BIT 0

// Low byte fields
`define LO_MIN_BIT 5
`define LO_ANS_BIT 4
`define LO_LOW_QUALITY_WARNING_BIT 2
`define LO_CHANNEL_FREE_FLAG_BIT 1

// Edge flag vector positions
`define EF_PROTOCOL_RESET_FLAG 0
`define EF_DTE 1
`define EF_POS 2
`define EF_ANS 3
`define EF_LOW_QUALITY_WARNING 4
`define EF_COUNT 5

// Quality thresholds
`define QM_LOW_LIMIT 4'he
`define QM_ZERO 4'h0

// Reset values
`define BYTE_ZERO 8'h00
`define MASK_RESET 8'h00
`define CHAN_FREE_RESET 1'b1

// Timing
`define CLK_FREQ_KHZ 250000
`define CABLE_BIT_KHZ 10000
`define OVERSAMPLE 8
`define SAMPLE_DIV_LAST 4'((`CLK_FREQ_KHZ / (`CABLE_BIT_KHZ * `OVERSAMPLE)) - 1)

`endif

/* src/link_event_pkg.sv */
package link_event_pkg;
    typedef logic [7:0] byte_t;
    typedef logic [3:0] quality_t;
    typedef enum logic [1:0] {SMP_IDLE, SMP_RUN, SMP_DONE} sampler_state_t;
endpackage : link_event_pkg

/* src/sticky_flag.sv */
`timescale 1ns/100ps
`default_nettype none
module sticky_flag (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic nrst,
    // Condition and clear
    input wire logic cond,
    input wire logic clear,
    // Flag
    output logic flag
);
    logic prev_reg;
    logic prev_next;
    logic flag_reg;
    logic flag_next;

    always_comb begin
        prev_next = cond;
        // Set on rising condition, set wins over clear
        flag_next = (cond & ~prev_reg) | (flag_reg & ~clear);
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            prev_reg <= 1'b0;
            flag_reg <= 1'b0;
        end else begin
            prev_reg <= prev_next;
            flag_reg <= flag_next;
        end
    end

    assign flag = flag_reg;
endmodule : sticky_flag
`default_nettype wire

/* src/edge_sampler.sv */
`timescale 1ns/100ps
`default_nettype none
`include "link_event_defines.svh"
module edge_sampler (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic nrst,
    // Control
    input wire logic startup_active,
    input wire logic restart,
    // Cable
    input wire logic cable_in,
    // Pattern
    output link_event_pkg::byte_t edges
);
    import link_event_pkg::*;

    sampler_state_t state_reg, state_next;
    logic [3:0] div_reg, div_next;
    logic [2:0] phase_reg, phase_next;
    logic prev_reg, prev_next;
    logic first_reg, first_next;
    byte_t edges_reg, edges_next;
    logic sample_en;

    always_comb begin
        sample_en = (div_reg == `SAMPLE_DIV_LAST);
        // Eight samples per cable bit
        div_next = sample_en ? 4'h0 : 4'(div_reg + 4'h1);
        state_next = state_reg;
        phase_next = phase_reg;
        prev_next = prev_reg;
        first_next = first_reg;
        edges_next = edges_reg;
        case (state_reg)
            SMP_IDLE: begin
                if (startup_active) begin
                    state_next = SMP_RUN;
                    phase_next = 3'h0;
                    first_next = 1'b1;
                end
            end
            SMP_RUN: begin
                if (!startup_active) begin
                    state_next = SMP_DONE;
                end else if (sample_en) begin
                    phase_next = 3'(phase_reg + 3'h1);
                    prev_next = cable_in;
                    first_next = 1'b0;
                    if (!first_reg && (cable_in != prev_reg)) begin
                        edges_next[phase_reg] = 1'b1;
                    end
                end
            end
            SMP_DONE: begin
                state_next = SMP_DONE;
            end
            default: begin
                state_next = SMP_IDLE;
            end
        endcase
        if (restart) begin
            state_next = SMP_IDLE;
            edges_next = `BYTE_ZERO;
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            state_reg <= SMP_IDLE;
            div_reg <= 4'h0;
            phase_reg <= 3'h0;
            prev_reg <= 1'b0;
            first_reg <= 1'b1;
            edges_reg <= `BYTE_ZERO;
        end else begin
            state_reg <= state_next;
            div_reg <= div_next;
            phase_reg <= phase_next;
            prev_reg <= prev_next;
            first_reg <= first_next;
            edges_reg <= edges_next;
        end
    end

    assign edges = edges_reg;
endmodule : edge_sampler
`default_nettype wire

/* src/link_event_irq.sv */
`timescale 1ns/100ps
`default_nettype none
`include "link_event_defines.svh"
// Notes on behaviour
// - Protocol reset flag sets on host request, internal reset or external reset.
// - Accumulated errors, seen as quality reaching zero, force a protocol reset.
// - Message-init flag follows the encoder acknowledgment level.
// - Failed reply to a long message sets the answer-error flag.
// - Low-quality flag sets when quality falls below 14.
// - Channel-free is high when idle, low from long message until answer.
// - Unimplemented event and mask bits read as zero.
// - Interrupt rises when any enabled event flag is active.
// - High mask bits 6, 3, 1, 0 gate their events.
// - Low mask bits 5, 4, 2, 1 gate their events.
// - Each summary mask bit enables its remote summary bit.
// - Remote summary flag is OR of enabled remote summary bits.
// - Remote summary enable reads as OR of the summary mask.
// - At start-up each edge bit sets on a transition in its slot.
// - Edge sampler runs at eight times the cable bit rate.
// - Edge flags stay set until the host clears them.
// - Edge flags set again only after the condition left and returned.
// - Quality value reaching zero forces a protocol reset.
module link_event_irq (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic nrst,
    // Register port
    input wire link_event_pkg::byte_t reg_addr,
    input wire link_event_pkg::byte_t reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output link_event_pkg::byte_t reg_rdata,
    // Link status
    input wire link_event_pkg::quality_t quality_value,
    input wire logic ext_reset_in,
    input wire logic msg_init_ack,
    input wire logic answer_fail,
    input wire logic long_msg_start,
    input wire logic long_answer_done,
    input wire logic position_error,
    input wire logic estimator_deviation_error,
    input wire link_event_pkg::byte_t remote_summary,
    // Start-up edge sampling
    input wire logic startup_active,
    input wire logic cable_in,
    // Outputs
    output logic protocol_reset_out,
    output logic param_channel_reset,
    output logic irq
);
    import link_event_pkg::*;

    byte_t high_mask_reg, high_mask_next;
    byte_t low_mask_reg, low_mask_next;
    byte_t sum_mask_reg, sum_mask_next;
    byte_t rdata_reg, rdata_next;
    logic irq_reg, irq_next;
    logic proto_rst_reg, proto_rst_next;
    logic chan_rst_reg, chan_rst_next;
    logic chan_free_reg, chan_free_next;
    logic qz_prev_reg, qz_prev_next;
    logic sum_flag_reg, sum_flag_next;
    logic min_flag_reg, min_flag_next;

    logic wr_sys, wr_evt_h, wr_evt_l;
    logic proto_evt, quality_zero;
    logic [`EF_COUNT-1:0] ef_cond, ef_clear, ef_flag;
    byte_t hi_flags, lo_flags, hi_mask_view, edges;

    always_comb begin
        wr_sys = reg_wr && (reg_addr == `OFF_SYSTEM_CONTROL_REG);
        wr_evt_h = reg_wr && (reg_addr == `OFF_EVT_H);
        wr_evt_l = reg_wr && (reg_addr == `OFF_EVT_L);
        quality_zero = (quality_value == `QM_ZERO);
        // Host request, external pin, or quality exhausted
        proto_evt = (wr_sys && reg_wdata[`SYS_PROTO_RST_BIT]) || ext_reset_in
            || (quality_zero && !qz_prev_reg);
        ef_cond = '0;
        ef_cond[`EF_PROTOCOL_RESET_FLAG] = proto_evt;
        ef_cond[`EF_DTE] = estimator_deviation_error;
        ef_cond[`EF_POS] = position_error;
        ef_cond[`EF_ANS] = answer_fail;
        ef_cond[`EF_LOW_QUALITY_WARNING] = (quality_value < `QM_LOW_LIMIT);
        // Write one clears that flag only
        ef_clear = '0;
        ef_clear[`EF_PROTOCOL_RESET_FLAG] = wr_evt_h && reg_wdata[`HI_PROTOCOL_RESET_FLAG_BIT];
        ef_clear[`EF_DTE] = wr_evt_h && reg_wdata[`HI_DTE_BIT];
        ef_clear[`EF_POS] = wr_evt_h && reg_wdata[`HI_POS_BIT];
        ef_clear[`EF_ANS] = wr_evt_l && reg_wdata[`LO_ANS_BIT];
        ef_clear[`EF_LOW_QUALITY_WARNING] = wr_evt_l && reg_wdata[`LO_LOW_QUALITY_WARNING_BIT];
    end

    genvar gi;
    generate
        for (gi = 0; gi < `EF_COUNT; gi++) begin : g_flag
            sticky_flag u_flag (
                .clk_sys(clk_sys),
                .nrst(nrst),
                .cond(ef_cond[gi]),
                .clear(ef_clear[gi]),
                .flag(ef_flag[gi])
            );
        end
    endgenerate

    edge_sampler u_edges (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .startup_active(startup_active),
        .restart(proto_rst_reg),
        .cable_in(cable_in),
        .edges(edges)
    );

    always_comb begin
        hi_flags = `BYTE_ZERO;
        hi_flags[`HI_IRQ_BIT] = irq_reg;
        hi_flags[`HI_SUM_BIT] = sum_flag_reg;
        hi_flags[`HI_POS_BIT] = ef_flag[`EF_POS];
        hi_flags[`HI_DTE_BIT] = ef_flag[`EF_DTE];
        hi_flags[`HI_PROTOCOL_RESET_FLAG_BIT] = ef_flag[`EF_PROTOCOL_RESET_FLAG];
        // Unimplemented positions stay zero
        lo_flags = `BYTE_ZERO;
        lo_flags[`LO_MIN_BIT] = min_flag_reg;
        lo_flags[`LO_ANS_BIT] = ef_flag[`EF_ANS];
        lo_flags[`LO_LOW_QUALITY_WARNING_BIT] = ef_flag[`EF_LOW_QUALITY_WARNING];
        lo_flags[`LO_CHANNEL_FREE_FLAG_BIT] = chan_free_reg;
        hi_mask_view = high_mask_reg;
        hi_mask_view[`HI_SUM_BIT] = |sum_mask_reg;
    end

    always_comb begin
        high_mask_next = high_mask_reg;
        low_mask_next = low_mask_reg;
        sum_mask_next = sum_mask_reg;
        if (reg_wr && (reg_addr == `OFF_MASK_H)) begin
            high_mask_next = `BYTE_ZERO;
            high_mask_next[`HI_POS_BIT] = reg_wdata[`HI_POS_BIT];
            high_mask_next[`HI_DTE_BIT] = reg_wdata[`HI_DTE_BIT];
            high_mask_next[`HI_PROTOCOL_RESET_FLAG_BIT] = reg_wdata[`HI_PROTOCOL_RESET_FLAG_BIT];
        end
        if (reg_wr && (reg_addr == `OFF_MASK_L)) begin
            low_mask_next = `BYTE_ZERO;
            low_mask_next[`LO_MIN_BIT] = reg_wdata[`LO_MIN_BIT];
            low_mask_next[`LO_ANS_BIT] = reg_wdata[`LO_ANS_BIT];
            low_mask_next[`LO_LOW_QUALITY_WARNING_BIT] = reg_wdata[`LO_LOW_QUALITY_WARNING_BIT];
            low_mask_next[`LO_CHANNEL_FREE_FLAG_BIT] = reg_wdata[`LO_CHANNEL_FREE_FLAG_BIT];
        end
        if (reg_wr && (reg_addr == `OFF_REMOTE_SUMMARY_MASK)) begin
            sum_mask_next = reg_wdata;
        end
    end

    always_comb begin
        qz_prev_next = quality_zero;
        proto_rst_next = proto_evt;
        chan_rst_next = wr_sys && reg_wdata[`SYS_CHAN_RST_BIT];
        sum_flag_next = |(remote_summary & sum_mask_reg);
        min_flag_next = msg_init_ack;
        chan_free_next = chan_free_reg;
        if (long_msg_start) begin
            chan_free_next = 1'b0;
        end
        if (long_answer_done || chan_rst_reg || proto_rst_reg) begin
            chan_free_next = 1'b1;
        end
        // Masked events combine onto one interrupt
        irq_next = |(hi_flags & hi_mask_view & ~(8'h1 << `HI_IRQ_BIT))
            || |(lo_flags & low_mask_reg);
    end

    always_comb begin
        rdata_next = `BYTE_ZERO;
        if (reg_rd) begin
            case (reg_addr)
                `OFF_EVT_H: rdata_next = hi_flags;
                `OFF_EVT_L: rdata_next = lo_flags;
                `OFF_MASK_H: rdata_next = hi_mask_view;
                `OFF_MASK_L: rdata_next = low_mask_reg;
                `OFF_EDGES: rdata_next = edges;
                default: rdata_next = `BYTE_ZERO;
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            high_mask_reg <= `MASK_RESET;
            low_mask_reg <= `MASK_RESET;
            sum_mask_reg <= `MASK_RESET;
            rdata_reg <= `BYTE_ZERO;
            irq_reg <= 1'b0;
            proto_rst_reg <= 1'b0;
            chan_rst_reg <= 1'b0;
            chan_free_reg <= `CHAN_FREE_RESET;
            qz_prev_reg <= 1'b0;
            sum_flag_reg <= 1'b0;
            min_flag_reg <= 1'b0;
        end else begin
            high_mask_reg <= high_mask_next;
            low_mask_reg <= low_mask_next;
            sum_mask_reg <= sum_mask_next;
            rdata_reg <= rdata_next;
            irq_reg <= irq_next;
            proto_rst_reg <= proto_rst_next;
            chan_rst_reg <= chan_rst_next;
            chan_free_reg <= chan_free_next;
            qz_prev_reg <= qz_prev_next;
            sum_flag_reg <= sum_flag_next;
            min_flag_reg <= min_flag_next;
        end
    end

    assign reg_rdata = rdata_reg;
    assign protocol_reset_out = proto_rst_reg;
    assign param_channel_reset = chan_rst_reg;
    assign irq = irq_reg;

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!nrst);

    chk_protocol_reset_flag_flag_set: assert property (proto_evt |=> ef_flag[`EF_PROTOCOL_RESET_FLAG])
        else $error("protocol reset did not set its flag");
    chk_quality_zero_rst: assert property (
        $rose(quality_zero) |=> protocol_reset_out ##1 ef_flag[`EF_PROTOCOL_RESET_FLAG])
        else $error("quality zero did not force protocol reset");
    chk_min_level: assert property (min_flag_reg == $past(msg_init_ack) || $rose(nrst))
        else $error("message init flag does not follow acknowledgment");
    chk_ans_flag_set: assert property ($rose(answer_fail) |=> ef_flag[`EF_ANS])
        else $error("answer failure did not set flag");
    chk_low_quality_set: assert property (
        $fell(quality_value >= `QM_LOW_LIMIT) |=> ef_flag[`EF_LOW_QUALITY_WARNING])
        else $error("low quality did not set warning");
    chk_free_clear: assert property (
        long_msg_start && !long_answer_done && !chan_rst_reg && !proto_rst_reg
        |=> !chan_free_reg)
        else $error("channel free not cleared by long message");
    chk_low_reserved: assert property (reg_rd && reg_addr == `OFF_EVT_L
        |=> reg_rdata[7:6] == 2'b00 && !reg_rdata[3] && !reg_rdata[0])
        else $error("reserved low event bits read nonzero");
    chk_irq_low_gate: assert property (|(lo_flags & low_mask_reg) |=> irq)
        else $error("enabled low event did not raise interrupt");
    chk_irq_blocked: assert property (
        !(|(hi_flags & hi_mask_view & 8'h7f)) && !(|(lo_flags & low_mask_reg))
        |=> !irq)
        else $error("interrupt raised with no enabled event");
    chk_sum_or: assert property (
        |(remote_summary & sum_mask_reg) |=> sum_flag_reg)
        else $error("remote summary flag missed enabled bit");
    chk_remote_summary_enable_read: assert property (reg_rd && reg_addr == `OFF_MASK_H
        |=> reg_rdata[`HI_SUM_BIT] == $past(|sum_mask_reg))
        else $error("summary enable read is not OR of mask");
    chk_flag_hold: assert property (
        ef_flag[`EF_ANS] && !ef_clear[`EF_ANS] |=> ef_flag[`EF_ANS])
        else $error("answer flag dropped without clear");
endmodule : link_event_irq
`default_nettype wire

/* bench/remote_encoder_model.sv */
`timescale 1ns/100ps
`default_nettype none
module remote_encoder_model #(
    parameter int ANSWER_CLKS = 6,
    parameter int BIT_CLKS = 24
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic nrst,
    // Control from the bench
    input wire logic long_msg_start,
    input wire logic [1:0] reply_mode,
    input wire logic test_signal_en,
    // Replies and cable
    output logic long_answer_done,
    output logic answer_fail,
    output logic cable_in
);
    // Reply modes: 0 prompt, 1 slow, 2 silent, 3 failed reply
    int wait_cnt;
    int bit_cnt;
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            wait_cnt <= 0;
            bit_cnt <= 0;
            long_answer_done <= 1'b0;
            answer_fail <= 1'b0;
            cable_in <= 1'b0;
        end else begin
            long_answer_done <= 1'b0;
            answer_fail <= 1'b0;
            if (long_msg_start && reply_mode != 2'h2) begin
                wait_cnt <= (reply_mode == 2'h1) ? 4 * ANSWER_CLKS : ANSWER_CLKS;
            end else if (wait_cnt == 1) begin
                wait_cnt <= 0;
                if (reply_mode == 2'h3) begin
                    answer_fail <= 1'b1;
                end else begin
                    long_answer_done <= 1'b1;
                end
            end else if (wait_cnt > 1) begin
                wait_cnt <= wait_cnt - 1;
            end
            // Test signal toggles once per cable bit
            if (test_signal_en) begin
                bit_cnt <= (bit_cnt == BIT_CLKS - 1) ? 0 : bit_cnt + 1;
                if (bit_cnt == BIT_CLKS - 1) begin
                    cable_in <= ~cable_in;
                end
            end
        end
    end
endmodule : remote_encoder_model
`default_nettype wire

/* bench/link_event_interrupt_masking_tb.sv */
`timescale 1ns/100ps
`default_nettype none
`include "link_event_defines.svh"
module link_event_interrupt_masking_tb;
    import link_event_pkg::*;
    logic clk_sys = 1'b0, nrst = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, ext_reset_in = 1'b0;
    logic msg_init_ack = 1'b0, long_msg_start = 1'b0, position_error = 1'b0;
    logic estimator_deviation_error = 1'b0, startup_active = 1'b0, test_en = 1'b0;
    logic answer_fail, long_answer_done, cable_in, protocol_reset_out, param_channel_reset, irq;
    logic [1:0] reply_mode = 2'h0;
    byte_t reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, remote_summary = 8'h00, d;
    quality_t quality_value = 4'hf;
    int errors = 0, total_checks = 0, protocol_reset_flag_cnt = 0, chan_cnt = 0;
    byte_t lo_bits [4] = '{8'h20, 8'h10, 8'h04, 8'h02};
    byte_t hi_bits [3] = '{8'h08, 8'h02, 8'h01};
    always #2 clk_sys = ~clk_sys;
    always @(posedge clk_sys) begin
        protocol_reset_flag_cnt <= protocol_reset_flag_cnt + (protocol_reset_out === 1'b1);
        chan_cnt <= chan_cnt + (param_channel_reset === 1'b1);
    end
    link_event_irq link_event_irq_inst (.clk_sys(clk_sys), .nrst(nrst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .quality_value(quality_value), .ext_reset_in(ext_reset_in),
        .msg_init_ack(msg_init_ack), .answer_fail(answer_fail), .long_msg_start(long_msg_start),
        .long_answer_done(long_answer_done), .position_error(position_error),
        .estimator_deviation_error(estimator_deviation_error), .remote_summary(remote_summary),
        .startup_active(startup_active), .cable_in(cable_in),
        .protocol_reset_out(protocol_reset_out), .param_channel_reset(param_channel_reset),
        .irq(irq));
    remote_encoder_model remote_encoder_model_inst (.clk_sys(clk_sys), .nrst(nrst),
        .long_msg_start(long_msg_start), .reply_mode(reply_mode), .test_signal_en(test_en),
        .long_answer_done(long_answer_done), .answer_fail(answer_fail), .cable_in(cable_in));
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
    endtask : tick
    task automatic chk(input string nm, input byte_t e, input byte_t g);
        total_checks++;
        if (g !== e) begin
            errors++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic wr(input byte_t a, input byte_t v);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input byte_t a, output byte_t v);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1 v = reg_rdata;
    endtask : rd
    task automatic rdc(input byte_t a, input byte_t m, input byte_t e);
        byte_t v;
        rd(a, v);
        chk("reg", e, v & m);
    endtask : rdc
    task automatic irqc(input logic e);
        tick(3);
        #1 chk("irq", {7'h0, e}, {7'h0, irq});
    endtask : irqc
    task automatic long_msg();
        @(posedge clk_sys);
        long_msg_start <= 1'b1;
        @(posedge clk_sys);
        long_msg_start <= 1'b0;
    endtask : long_msg
    task automatic stop_test();
        $display("errors=%0d total_checks=%0d", errors, total_checks);
        if (errors == 0 && total_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : stop_test
    initial begin
        tick(20000);
        errors++;
        stop_test();
    end
    initial begin
        tick(10);
        nrst <= 1'b1;
        rdc(`OFF_EVT_L, 8'hff, 8'h02);
        rdc(`OFF_REMOTE_SUMMARY_MASK, 8'hff, 8'h00);
        rdc(8'h0f, 8'hff, 8'h00);
        wr(`OFF_MASK_L, 8'hff);
        rdc(`OFF_MASK_L, 8'hff, 8'h36);
        wr(`OFF_MASK_H, 8'hff);
        rdc(`OFF_MASK_H, 8'hff, 8'h0b);
        wr(`OFF_MASK_L, 8'h00);
        wr(`OFF_MASK_H, 8'h00);
        // Low quality threshold, stickiness, clearing
        quality_value <= 4'he;
        tick(3);
        rdc(`OFF_EVT_L, 8'h04, 8'h00);
        quality_value <= 4'hd;
        tick(3);
        rdc(`OFF_EVT_L, 8'h04, 8'h04);
        quality_value <= 4'hf;
        tick(3);
        rdc(`OFF_EVT_L, 8'h04, 8'h04);
        quality_value <= 4'hd;
        wr(`OFF_EVT_L, 8'h04);
        tick(3);
        rdc(`OFF_EVT_L, 8'h04, 8'h00);
        quality_value <= 4'hf;
        tick(3);
        quality_value <= 4'hd;
        tick(3);
        rdc(`OFF_EVT_L, 8'h06, 8'h06);
        // Long messages: prompt, silent with host timeout, failed reply
        long_msg();
        rdc(`OFF_EVT_L, 8'h02, 8'h00);
        tick(8);
        rdc(`OFF_EVT_L, 8'h02, 8'h02);
        reply_mode <= 2'h2;
        long_msg();
        tick(30);
        rdc(`OFF_EVT_L, 8'h02, 8'h00);
        wr(`OFF_SYSTEM_CONTROL_REG, 8'h02);
        tick(3);
        rdc(`OFF_EVT_L, 8'h02, 8'h02);
        chk("chan_reset", 8'h01, 8'(chan_cnt));
        reply_mode <= 2'h3;
        long_msg();
        tick(8);
        rdc(`OFF_EVT_L, 8'h10, 8'h10);
        reply_mode <= 2'h1;
        wr(`OFF_EVT_L, 8'h10);
        long_msg();
        tick(30);
        rdc(`OFF_EVT_L, 8'h12, 8'h02);
        // Message init follows the acknowledgment; no messages meanwhile
        msg_init_ack <= 1'b1;
        tick(3);
        rdc(`OFF_EVT_L, 8'h20, 8'h20);
        msg_init_ack <= 1'b0;
        tick(3);
        rdc(`OFF_EVT_L, 8'h20, 8'h00);
        msg_init_ack <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            wr(`OFF_MASK_L, lo_bits[i]);
            irqc(i != 1);
        end
        wr(`OFF_MASK_L, 8'h36);
        irqc(1'b1);
        wr(`OFF_MASK_L, 8'h00);
        irqc(1'b0);
        // High events and masks
        position_error <= 1'b1;
        estimator_deviation_error <= 1'b1;
        @(posedge clk_sys);
        ext_reset_in <= 1'b1;
        @(posedge clk_sys);
        ext_reset_in <= 1'b0;
        tick(3);
        rdc(`OFF_EVT_H, 8'h0b, 8'h0b);
        for (int i = 0; i < 3; i++) begin
            wr(`OFF_MASK_H, hi_bits[i]);
            irqc(1'b1);
        end
        wr(`OFF_MASK_H, 8'h40);
        irqc(1'b0);
        wr(`OFF_EVT_H, 8'h0b);
        tick(3);
        rdc(`OFF_EVT_H, 8'h0b, 8'h00);
        wr(`OFF_SYSTEM_CONTROL_REG, 8'h01);
        tick(3);
        rdc(`OFF_EVT_H, 8'h01, 8'h01);
        wr(`OFF_EVT_H, 8'h01);
        quality_value <= 4'h0;
        tick(4);
        rdc(`OFF_EVT_H, 8'h01, 8'h01);
        chk("protocol_reset_flag_pulses", 8'h03, 8'(protocol_reset_flag_cnt));
        quality_value <= 4'hf;
        // Remote summary gating
        wr(`OFF_REMOTE_SUMMARY_MASK, 8'h04);
        rdc(`OFF_MASK_H, 8'h40, 8'h40);
        remote_summary <= 8'h0a;
        tick(3);
        rdc(`OFF_EVT_H, 8'h40, 8'h00);
        irqc(1'b0);
        remote_summary <= 8'h06;
        tick(3);
        rdc(`OFF_EVT_H, 8'h40, 8'h40);
        irqc(1'b1);
        remote_summary <= 8'h00;
        wr(`OFF_REMOTE_SUMMARY_MASK, 8'h00);
        // Start-up edge pattern: test signal toggles once per cable bit
        startup_active <= 1'b1;
        test_en <= 1'b1;
        tick(240);
        startup_active <= 1'b0;
        tick(3);
        rd(`OFF_EDGES, d);
        chk("edge_bits", 8'h01, 8'($countones(d)));
        tick(50);
        rdc(`OFF_EDGES, 8'hff, d);
        wr(`OFF_SYSTEM_CONTROL_REG, 8'h01);
        tick(3);
        rdc(`OFF_EDGES, 8'hff, 8'h00);
        stop_test();
    end
endmodule : link_event_interrupt_masking_tb
`default_nettype wire
